// ---- pinmux_regs.svh ----
// Purpose: Register offsets, field masks and reset values of the pin mux
// Assumes: 32-bit byte addresses on the register port
// Notes:   Write masks mark the writable bits; fixed values fill the rest
`ifndef PINMUX_REGS_SVH
`define PINMUX_REGS_SVH

// Port data latches
`define ADDR_PORT0_DATA        32'hfffff000
`define ADDR_PORT1_DATA        32'hfffff002
`define ADDR_PORT2_DATA        32'hfffff004
`define ADDR_PORT3_DATA        32'hfffff006
// Direction registers
`define ADDR_PORT0_DIRECTION   32'hfffff020
`define ADDR_PORT1_DIRECTION   32'hfffff022
`define ADDR_PORT2_DIRECTION   32'hfffff024
`define ADDR_PORT3_DIRECTION   32'hfffff026
// Function enable registers
`define ADDR_PORT0_FUNC_EN     32'hfffff040
`define ADDR_PORT1_FUNC_EN     32'hfffff042
`define ADDR_PORT2_FUNC_EN     32'hfffff044
`define ADDR_PORT3_FUNC_EN     32'hfffff046
// Function select registers
`define ADDR_PORT0_FUNC_SEL    32'hfffff580
`define ADDR_PORT1_FUNC_SEL    32'hfffff582
`define ADDR_PORT3_FUNC_SEL    32'hfffff586

// Implemented pins of each port
`define PINS_PORT0             8'hf5
`define PINS_PORT1             8'hf5
`define PINS_PORT2             8'hfd
`define PINS_PORT3             8'h18
// Writable bits where they differ from the pin set
`define WMASK_PORT2_DIRECTION  8'hfc
`define WMASK_PORT2_FUNC_EN    8'hfc
`define WMASK_FUNC_SEL_01      8'hf0
// Values held in the bits that writes cannot change
`define FIXED_DIRECTION        8'hff
`define FIXED_ZERO             8'h00
`define FIXED_PORT2_FUNC_EN    8'h01

// Reset values
`define RST_DATA               8'h00
`define RST_DIRECTION          8'hff
`define RST_FUNC_EN            8'h00
`define RST_PORT2_FUNC_EN      8'h01
`define RST_FUNC_SEL           8'h00

`endif

// ---- pinmux_pkg.sv ----
// Purpose: Shared types of the pin mux
// Assumes: Nothing beyond the register header
// Notes:   Offsets and values live in pinmux_regs.svh
package pinmux_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [31:0] addr_t;
	typedef logic [15:0] pin_drive_t;
endpackage

// ---- port_pin_mux.sv ----
// Purpose: Pin function mux and direction control for ports 0 to 3
// Assumes: One 50 MHz clock, register port with read data one cycle later
// Notes:   Pin outputs are registered, one cycle late; peripheral inputs follow the pins five cycles late
// What this block does
// RULE_01: Direction bit 0 turns the pin driver on, 1 makes it input.
// RULE_02: Port 0 enable bits 7..4 pick plain I/O or select-chosen function.
// RULE_03: Port 0 select bit 0 gives interrupt input, 1 gives DMA request.
// RULE_04: Port 0 and 1 select bits 3..0 read 0, writes ignored.
// RULE_05: In plain port mode the pin's select bit has no effect.
// RULE_06: Port 0 enable bit 2 makes P02 the first timer clear input.
// RULE_07: Port 0 enable bit 0 drives P00 from the first timer output.
// RULE_08: Port 1 enable bits 7..4 pick plain I/O or select-chosen function.
// RULE_09: Port 1 select bit 0 gives interrupt input, 1 DMA acknowledge out.
// RULE_10: Port 1 bit 2 gives second timer clear, bit 0 second timer out.
// RULE_11: Software writes 0 to unused enable bits 3 and 1 of ports 0, 1.
// RULE_12: P20 always feeds the non-maskable interrupt input.
// RULE_13: Port 2 direction bit 0 is held at 1.
// RULE_14: Port 2 enable bit 0 held 1, bit 1 held 0.
// RULE_15: Software writes 1 to unused low port 2 direction bits.
// RULE_16: Port 2 enable bits 7..2 hand pins to serial clock, receive, send.
// RULE_17: Serial mode input decides async or clocked owner of shared pins.
// RULE_18: Software keeps serial-related port 2 direction bits at 1.
// RULE_19: Port 3 enables P33 as timer count input, P34 as interrupt input.
// RULE_20: All direction, enable and select registers take byte or bit access.
// RULE_21: Software loads inactive latch level before entering control mode.
// RULE_22: Control mode routes peripheral value and enable to the pin.
// RULE_23: Data read gives pin level for inputs, latch value for outputs.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "pinmux_regs.svh"
module port_pin_mux
	import pinmux_pkg::*;
(
	input  wire logic        CORE_CLK_IN,
	input  wire logic        NRST_IN,
	// Register port
	input  wire logic [31:0] ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	input  wire logic        BIT_OP_IN,
	input  wire logic [2:0]  BIT_NUM_IN,
	output logic      [7:0]  RDATA_OUT,
	// Pins of ports 0 to 3
	input  wire logic [7:0]  P0_IN,
	output logic      [7:0]  P0_OUT,
	output logic      [7:0]  P0_OE_OUT,
	input  wire logic [7:0]  P1_IN,
	output logic      [7:0]  P1_OUT,
	output logic      [7:0]  P1_OE_OUT,
	input  wire logic [7:0]  P2_IN,
	output logic      [7:0]  P2_OUT,
	output logic      [7:0]  P2_OE_OUT,
	input  wire logic [7:0]  P3_IN,
	output logic      [7:0]  P3_OUT,
	output logic      [7:0]  P3_OE_OUT,
	// Pulse unit timers
	input  wire logic        TIMER_OUT_A_IN,
	input  wire logic        TIMER_OUT_B_IN,
	output logic             TIMER_CLEAR_A_OUT,
	output logic             TIMER_CLEAR_B_OUT,
	output logic             TIMER_COUNT_INPUT_C_OUT,
	// Interrupts and DMA
	output logic      [3:0]  EXT_IRQ_GROUP_A_OUT,
	output logic      [3:0]  EXT_IRQ_GROUP_B_OUT,
	output logic             EXT_IRQ_C_OUT,
	output logic             NMI_OUT,
	output logic      [3:0]  DMA_REQUEST_LINE_OUT,
	input  wire logic [3:0]  DMA_ACKNOWLEDGE_LINE_IN,
	// Serial channels, index 0 and 1
	input  wire logic [1:0]  SERIAL_CLOCKED_IN,
	input  wire logic [1:0]  ASYNC_TX_IN,
	input  wire logic [1:0]  CLOCKED_TX_IN,
	input  wire logic [1:0]  SERIAL_TX_OE_IN,
	input  wire logic [1:0]  SERIAL_CLK_VAL_IN,
	input  wire logic [1:0]  SERIAL_CLK_OE_IN,
	output logic      [1:0]  ASYNC_RX_OUT,
	output logic      [1:0]  CLOCKED_RX_OUT,
	output logic      [1:0]  SERIAL_CLK_PIN_OUT
);
	// Register state
	byte_t data0_q, data1_q, data2_q, data3_q;
	byte_t dir0_q, dir1_q, dir2_q, dir3_q;
	byte_t fen0_q, fen1_q, fen2_q, fen3_q;
	byte_t fsel0_q, fsel1_q, fsel3_q;
	byte_t rdata_q;
	// Pin input synchronisers, ports packed 3..0
	logic [31:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
	// Peripheral drive per port, {enable, value}; port 3 only takes inputs
	byte_t per_val0, per_val1, per_val2;
	byte_t per_oe0, per_oe1, per_oe2;
	pin_drive_t drv0_d, drv1_d, drv2_d, drv3_d;
	byte_t pin0, pin1, pin2, pin3;
	// Merge a byte or single-bit write, then pin fixed bits
	function automatic byte_t merge_write(
		input byte_t      old,
		input byte_t      wd,
		input logic       bop,
		input logic [2:0] bn,
		input byte_t      wmask,
		input byte_t      fixed
	);
		byte_t m;
		m = bop ? old : wd;
		if (bop) begin
			m[bn] = wd[0];
		end
		return (m & wmask) | (fixed & ~wmask);
	endfunction
	// Pick control drive or port drive per bit, result {oe, out}
	function automatic pin_drive_t pin_drive(
		input byte_t ctl,
		input byte_t pval,
		input byte_t poe,
		input byte_t latch,
		input byte_t dir
	);
		byte_t o, e;
		o = (ctl & pval) | (~ctl & latch);
		e = (ctl & poe) | (~ctl & ~dir);
		return {e, o};
	endfunction
	// Port data view: pin level for inputs, latch for outputs
	function automatic byte_t data_view(
		input byte_t pin,
		input byte_t latch,
		input byte_t dir,
		input byte_t impl
	);
		return ((pin & dir) | (latch & ~dir)) & impl; // RULE_23
	endfunction
	function automatic logic wr_hit(input addr_t a, input addr_t reg_addr);
		return a == reg_addr;
	endfunction
	assign pin0 = pin_q[7:0];
	assign pin1 = pin_q[15:8];
	assign pin2 = pin_q[23:16];
	assign pin3 = pin_q[31:24];
	// Three-stage sync; a change counts once stages two and three agree
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pin_s1_q <= 32'h00000000;
			pin_s2_q <= 32'h00000000;
			pin_s3_q <= 32'h00000000;
			pin_q    <= 32'h00000000;
		end else begin
			pin_s1_q <= {P3_IN, P2_IN, P1_IN, P0_IN};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= (pin_s2_q & pin_s3_q) |
				(pin_q & (pin_s2_q ^ pin_s3_q));
		end
	end
	// Data latches; unimplemented bits stay zero
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			data0_q <= `RST_DATA;
			data1_q <= `RST_DATA;
			data2_q <= `RST_DATA;
			data3_q <= `RST_DATA;
		end else if (WR_IN) begin
			if (wr_hit(ADDR_IN, `ADDR_PORT0_DATA)) begin
				data0_q <= merge_write(data0_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT0, `FIXED_ZERO);
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT1_DATA)) begin
				data1_q <= merge_write(data1_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT1, `FIXED_ZERO);
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT2_DATA)) begin
				data2_q <= merge_write(data2_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `WMASK_PORT2_DIRECTION, `FIXED_ZERO);
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT3_DATA)) begin
				data3_q <= merge_write(data3_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT3, `FIXED_ZERO);
			end
		end
	end
	// Direction registers; unused bits and P20 read as input
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			dir0_q <= `RST_DIRECTION;
			dir1_q <= `RST_DIRECTION;
			dir2_q <= `RST_DIRECTION;
			dir3_q <= `RST_DIRECTION;
		end else if (WR_IN) begin
			if (wr_hit(ADDR_IN, `ADDR_PORT0_DIRECTION)) begin
				dir0_q <= merge_write(dir0_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT0, `FIXED_DIRECTION); // RULE_20
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT1_DIRECTION)) begin
				dir1_q <= merge_write(dir1_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT1, `FIXED_DIRECTION);
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT2_DIRECTION)) begin
				// Bit 0 is forced high, so a write of 0 there is lost
				dir2_q <= merge_write(dir2_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `WMASK_PORT2_DIRECTION,
					`FIXED_DIRECTION); // RULE_13
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT3_DIRECTION)) begin
				dir3_q <= merge_write(dir3_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT3, `FIXED_DIRECTION); // RULE_19
			end
		end
	end
	// Function enable registers
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			fen0_q <= `RST_FUNC_EN;
			fen1_q <= `RST_FUNC_EN;
			fen2_q <= `RST_PORT2_FUNC_EN;
			fen3_q <= `RST_FUNC_EN;
		end else if (WR_IN) begin
			// Unused bits 3 and 1 are masked even if software misbehaves
			if (wr_hit(ADDR_IN, `ADDR_PORT0_FUNC_EN)) begin
				fen0_q <= merge_write(fen0_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT0, `FIXED_ZERO); // RULE_20
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT1_FUNC_EN)) begin
				fen1_q <= merge_write(fen1_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT1, `FIXED_ZERO);
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT2_FUNC_EN)) begin
				fen2_q <= merge_write(fen2_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `WMASK_PORT2_FUNC_EN,
					`FIXED_PORT2_FUNC_EN); // RULE_14
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT3_FUNC_EN)) begin
				fen3_q <= merge_write(fen3_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT3, `FIXED_ZERO);
			end
		end
	end
	// Function select registers; low nibble of ports 0 and 1 fixed at 0
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			fsel0_q <= `RST_FUNC_SEL;
			fsel1_q <= `RST_FUNC_SEL;
			fsel3_q <= `RST_FUNC_SEL;
		end else if (WR_IN) begin
			if (wr_hit(ADDR_IN, `ADDR_PORT0_FUNC_SEL)) begin
				fsel0_q <= merge_write(fsel0_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `WMASK_FUNC_SEL_01, `FIXED_ZERO); // RULE_04
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT1_FUNC_SEL)) begin
				fsel1_q <= merge_write(fsel1_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `WMASK_FUNC_SEL_01, `FIXED_ZERO); // RULE_04
			end
			if (wr_hit(ADDR_IN, `ADDR_PORT3_FUNC_SEL)) begin
				fsel3_q <= merge_write(fsel3_q, WDATA_IN, BIT_OP_IN,
					BIT_NUM_IN, `PINS_PORT3, `FIXED_ZERO);
			end
		end
	end
	// Read mux; unmapped addresses and idle cycles give zero
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_q <= 8'h00;
		end else if (RD_IN) begin
			byte_t v;
			v = 8'h00;
			case (ADDR_IN)
				`ADDR_PORT0_DATA: v = data_view(pin0, data0_q, dir0_q,
					`PINS_PORT0);
				`ADDR_PORT1_DATA: v = data_view(pin1, data1_q, dir1_q,
					`PINS_PORT1);
				`ADDR_PORT2_DATA: v = data_view(pin2, data2_q, dir2_q,
					`PINS_PORT2);
				`ADDR_PORT3_DATA: v = data_view(pin3, data3_q, dir3_q,
					`PINS_PORT3);
				`ADDR_PORT0_DIRECTION: v = dir0_q;
				`ADDR_PORT1_DIRECTION: v = dir1_q;
				`ADDR_PORT2_DIRECTION: v = dir2_q;
				`ADDR_PORT3_DIRECTION: v = dir3_q;
				`ADDR_PORT0_FUNC_EN: v = fen0_q;
				`ADDR_PORT1_FUNC_EN: v = fen1_q;
				`ADDR_PORT2_FUNC_EN: v = fen2_q;
				`ADDR_PORT3_FUNC_EN: v = fen3_q;
				`ADDR_PORT0_FUNC_SEL: v = fsel0_q;
				`ADDR_PORT1_FUNC_SEL: v = fsel1_q;
				`ADDR_PORT3_FUNC_SEL: v = fsel3_q;
				default: v = 8'h00;
			endcase
			// Bit access returns the chosen bit in bit 0
			rdata_q <= BIT_OP_IN ? {7'h00, v[BIT_NUM_IN]} : v; // RULE_20
		end else begin
			rdata_q <= 8'h00;
		end
	end
	// Peripheral drive per pin while in control mode
	always_comb begin
		per_val0 = 8'h00;
		per_oe0  = 8'h00;
		per_val1 = 8'h00;
		per_oe1  = 8'h00;
		per_val2 = 8'h00;
		per_oe2  = 8'h00;
		// P00 timer output; P02 and P04..P07 are inputs
		per_val0[0] = TIMER_OUT_A_IN; // RULE_07
		per_oe0[0]  = 1'b1; // RULE_07
		// P10 timer output; P14..P17 acknowledge out when selected
		per_val1[0] = TIMER_OUT_B_IN; // RULE_10
		per_oe1[0]  = 1'b1; // RULE_10
		per_val1[7:4] = DMA_ACKNOWLEDGE_LINE_IN; // RULE_09
		per_oe1[7:4]  = fsel1_q[7:4]; // RULE_09
		// Serial transmit: owner chosen by the channel's mode input
		per_val2[2] = SERIAL_CLOCKED_IN[0] ?
			CLOCKED_TX_IN[0] : ASYNC_TX_IN[0]; // RULE_17
		per_oe2[2]  = SERIAL_TX_OE_IN[0];
		per_val2[5] = SERIAL_CLOCKED_IN[1] ?
			CLOCKED_TX_IN[1] : ASYNC_TX_IN[1]; // RULE_17
		per_oe2[5]  = SERIAL_TX_OE_IN[1];
		// Clock pin drives only for the clocked variant
		per_val2[4] = SERIAL_CLK_VAL_IN[0];
		per_oe2[4]  = SERIAL_CLK_OE_IN[0] & SERIAL_CLOCKED_IN[0]; // RULE_17
		per_val2[7] = SERIAL_CLK_VAL_IN[1];
		per_oe2[7]  = SERIAL_CLK_OE_IN[1] & SERIAL_CLOCKED_IN[1]; // RULE_17
	end
	// Enable bits steer the pins; P20 never drives since bit 0 is input
	assign drv0_d = pin_drive(fen0_q, per_val0, per_oe0,
		data0_q, dir0_q); // RULE_22
	assign drv1_d = pin_drive(fen1_q, per_val1, per_oe1,
		data1_q, dir1_q); // RULE_22
	assign drv2_d = pin_drive(fen2_q & `WMASK_PORT2_FUNC_EN, per_val2,
		per_oe2, data2_q, dir2_q); // RULE_16
	assign drv3_d = pin_drive(fen3_q, 8'h00, 8'h00,
		data3_q, dir3_q); // RULE_01
	// Registered pin drive; one cycle of delay keeps outputs glitch free
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			P0_OUT    <= 8'h00;
			P0_OE_OUT <= 8'h00;
			P1_OUT    <= 8'h00;
			P1_OE_OUT <= 8'h00;
			P2_OUT    <= 8'h00;
			P2_OE_OUT <= 8'h00;
			P3_OUT    <= 8'h00;
			P3_OE_OUT <= 8'h00;
		end else begin
			P0_OUT    <= drv0_d[7:0];
			P0_OE_OUT <= drv0_d[15:8]; // RULE_01
			P1_OUT    <= drv1_d[7:0];
			P1_OE_OUT <= drv1_d[15:8];
			P2_OUT    <= drv2_d[7:0];
			P2_OE_OUT <= drv2_d[15:8];
			P3_OUT    <= drv3_d[7:0];
			P3_OE_OUT <= drv3_d[15:8];
		end
	end
	// Peripheral inputs from pins; inactive low when the pin is a port
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			TIMER_CLEAR_A_OUT       <= 1'b0;
			TIMER_CLEAR_B_OUT       <= 1'b0;
			TIMER_COUNT_INPUT_C_OUT <= 1'b0;
			EXT_IRQ_GROUP_A_OUT     <= 4'h0;
			EXT_IRQ_GROUP_B_OUT     <= 4'h0;
			EXT_IRQ_C_OUT           <= 1'b0;
			DMA_REQUEST_LINE_OUT    <= 4'h0;
			NMI_OUT                 <= 1'b0;
		end else begin
			TIMER_CLEAR_A_OUT <= fen0_q[2] & pin0[2]; // RULE_06
			TIMER_CLEAR_B_OUT <= fen1_q[2] & pin1[2]; // RULE_10
			// Select bits only matter once the enable bit is set
			EXT_IRQ_GROUP_A_OUT <= fen0_q[7:4] & ~fsel0_q[7:4] &
				pin0[7:4]; // RULE_02 RULE_03 RULE_05
			DMA_REQUEST_LINE_OUT <= fen0_q[7:4] & fsel0_q[7:4] &
				pin0[7:4]; // RULE_03 RULE_05
			EXT_IRQ_GROUP_B_OUT <= fen1_q[7:4] & ~fsel1_q[7:4] &
				pin1[7:4]; // RULE_08 RULE_09 RULE_05
			TIMER_COUNT_INPUT_C_OUT <= fen3_q[3] & pin3[3]; // RULE_19
			EXT_IRQ_C_OUT <= fen3_q[4] & pin3[4]; // RULE_19
			// No register gates this pin
			NMI_OUT <= pin2[0]; // RULE_12
		end
	end
	// Serial receive and clock inputs, routed to the owning variant
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ASYNC_RX_OUT       <= 2'b00;
			CLOCKED_RX_OUT     <= 2'b00;
			SERIAL_CLK_PIN_OUT <= 2'b00;
		end else begin
			ASYNC_RX_OUT[0]   <= fen2_q[3] & ~SERIAL_CLOCKED_IN[0] &
				pin2[3]; // RULE_16 RULE_17
			CLOCKED_RX_OUT[0] <= fen2_q[3] & SERIAL_CLOCKED_IN[0] &
				pin2[3]; // RULE_17
			ASYNC_RX_OUT[1]   <= fen2_q[6] & ~SERIAL_CLOCKED_IN[1] &
				pin2[6]; // RULE_16 RULE_17
			CLOCKED_RX_OUT[1] <= fen2_q[6] & SERIAL_CLOCKED_IN[1] &
				pin2[6]; // RULE_17
			SERIAL_CLK_PIN_OUT[0] <= fen2_q[4] & pin2[4]; // RULE_16
			SERIAL_CLK_PIN_OUT[1] <= fen2_q[7] & pin2[7]; // RULE_16
		end
	end
	assign RDATA_OUT = rdata_q;
endmodule

// ---- port_pin_mux_assertions.sv ----
// Purpose: Port-level assertions for the pin function mux
// Assumes: One clock domain with an active-low asynchronous reset
// Notes:   Register checks look only at byte reads
`timescale 1ns/100ps
`include "pinmux_regs.svh"

module port_pin_mux_assertions
	import pinmux_pkg::*;
(
	input wire logic        CORE_CLK_IN,
	input wire logic        NRST_IN,
	input wire logic [31:0] ADDR_IN,
	input wire logic        RD_IN,
	input wire logic        BIT_OP_IN,
	input wire logic [7:0]  RDATA_OUT,
	input wire logic [7:0]  P2_IN,
	input wire logic [7:0]  P2_OE_OUT,
	input wire logic [3:0]  EXT_IRQ_GROUP_A_OUT,
	input wire logic [3:0]  DMA_REQUEST_LINE_OUT,
	input wire logic [1:0]  ASYNC_RX_OUT,
	input wire logic [1:0]  CLOCKED_RX_OUT,
	input wire logic        NMI_OUT
);
	// One domain, so clock and reset are stated once
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);

	// Read data stand only in the cycle after a read strobe
	a_rdata_idle_zero: assert property (
		!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data seen without a read");
	a_sel_low_zero: assert property (
		RD_IN && !BIT_OP_IN && (ADDR_IN == `ADDR_PORT0_FUNC_SEL ||
		ADDR_IN == `ADDR_PORT1_FUNC_SEL) |=> RDATA_OUT[3:0] == 4'h0)
		else $error("select low bits read nonzero");
	a_p2dir_bit_fixed: assert property (
		RD_IN && !BIT_OP_IN && ADDR_IN == `ADDR_PORT2_DIRECTION
		|=> RDATA_OUT[0])
		else $error("port 2 direction bit 0 read low");
	a_p2en_low_fixed: assert property (
		RD_IN && !BIT_OP_IN && ADDR_IN == `ADDR_PORT2_FUNC_EN
		|=> RDATA_OUT[1:0] == 2'b01)
		else $error("port 2 enable low bits changed");
	// Sync flops and filter need five edges, eight leaves margin
	a_nmi_follow_high: assert property (
		P2_IN[0] [*8] |=> NMI_OUT)
		else $error("nmi missed a steady high pin");
	a_nmi_follow_low: assert property (
		!P2_IN[0] [*8] |=> !NMI_OUT)
		else $error("nmi high on a steady low pin");
	a_nmi_pin_undriven: assert property (
		P2_OE_OUT[1:0] == 2'b00)
		else $error("nmi pin driven");
	a_irq_dma_split: assert property (
		(EXT_IRQ_GROUP_A_OUT & DMA_REQUEST_LINE_OUT) == 4'h0)
		else $error("pin routed to irq and dma at once");
	a_rx_one_owner: assert property (
		(ASYNC_RX_OUT & CLOCKED_RX_OUT) == 2'b00)
		else $error("both serial variants got receive data");
endmodule

// ---- board_pins_model.sv ----
// Purpose: Board side of the port pins
// Assumes: Each pin sees the device driver or a board source
// Notes:   No pulls; an undriven pin shows the level the bench picks
`timescale 1ns/100ps

module board_pins_model
	import pinmux_pkg::*;
(
	input  wire logic [31:0] oe_in,
	input  wire logic [31:0] drv_in,
	input  wire logic [31:0] lvl_in,
	output logic      [31:0] pin_out
);
	// Driver wins where enabled, so a stale latch cannot hide
	assign pin_out = (oe_in & drv_in) | (~oe_in & lvl_in);
endmodule

// ---- port_pin_mux_tb.sv ----
// Purpose: Self-checking bench for the port pin function mux
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Pin paths get eight cycles, above the five they need
`timescale 1ns/100ps
`include "pinmux_regs.svh"

module port_pin_mux_tb
	import pinmux_pkg::*;
;
	logic            core_clk = 1'b0;
	logic            nrst     = 1'b0;
	addr_t           addr     = '0;
	byte_t           wdata    = '0;
	logic            wr       = 1'b0;
	logic            rd       = 1'b0;
	logic            bop      = 1'b0;
	logic [2:0]      bnum     = '0;
	logic [3:0][7:0] lvl      = '0;
	logic [5:0]      per      = '0; // Timer a, timer b, dma acks
	logic [1:0]      s_mode   = '0;
	logic [9:0]      ser      = '0; // Tx a/c, tx oe, clk val, clk oe
	byte_t           rdata;
	logic [3:0][7:0] p_in, p_out, p_oe;
	logic [3:0]      irq_a, irq_b, dreq;
	logic [1:0]      a_rx, c_rx, ck_pin;
	logic            clr_a, clr_b, cnt_c, irq_c, nmi;
	int              failures = 0;
	int              cmp_count = 0;
	int              cycles = 0;
	addr_t reg_addr [11] = '{`ADDR_PORT0_DIRECTION, `ADDR_PORT1_DIRECTION,
		`ADDR_PORT2_DIRECTION, `ADDR_PORT3_DIRECTION, `ADDR_PORT0_FUNC_EN,
		`ADDR_PORT1_FUNC_EN, `ADDR_PORT2_FUNC_EN, `ADDR_PORT3_FUNC_EN,
		`ADDR_PORT0_FUNC_SEL, `ADDR_PORT1_FUNC_SEL, `ADDR_PORT3_FUNC_SEL};
	byte_t reg_mask [11] = '{8'hf5, 8'hf5, 8'hfc, 8'h18, 8'hf5, 8'hf5,
		8'hfc, 8'h18, 8'hf0, 8'hf0, 8'h18};
	// Fixed bits double as reset values of the whole table
	byte_t reg_fix [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	addr_t data_addr [4] = '{`ADDR_PORT0_DATA, `ADDR_PORT1_DATA,
		`ADDR_PORT2_DATA, `ADDR_PORT3_DATA};
	byte_t pin_set [4] = '{`PINS_PORT0, `PINS_PORT1, `PINS_PORT2,
		`PINS_PORT3};

	port_pin_mux i_dut (
		.CORE_CLK_IN(core_clk), .NRST_IN(nrst), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .BIT_OP_IN(bop),
		.BIT_NUM_IN(bnum), .RDATA_OUT(rdata),
		.P0_IN(p_in[0]), .P0_OUT(p_out[0]), .P0_OE_OUT(p_oe[0]),
		.P1_IN(p_in[1]), .P1_OUT(p_out[1]), .P1_OE_OUT(p_oe[1]),
		.P2_IN(p_in[2]), .P2_OUT(p_out[2]), .P2_OE_OUT(p_oe[2]),
		.P3_IN(p_in[3]), .P3_OUT(p_out[3]), .P3_OE_OUT(p_oe[3]),
		.TIMER_OUT_A_IN(per[5]), .TIMER_OUT_B_IN(per[4]),
		.TIMER_CLEAR_A_OUT(clr_a), .TIMER_CLEAR_B_OUT(clr_b),
		.TIMER_COUNT_INPUT_C_OUT(cnt_c), .EXT_IRQ_GROUP_A_OUT(irq_a),
		.EXT_IRQ_GROUP_B_OUT(irq_b), .EXT_IRQ_C_OUT(irq_c),
		.NMI_OUT(nmi), .DMA_REQUEST_LINE_OUT(dreq),
		.DMA_ACKNOWLEDGE_LINE_IN(per[3:0]), .SERIAL_CLOCKED_IN(s_mode),
		.ASYNC_TX_IN(ser[9:8]), .CLOCKED_TX_IN(ser[7:6]),
		.SERIAL_TX_OE_IN(ser[5:4]), .SERIAL_CLK_VAL_IN(ser[3:2]),
		.SERIAL_CLK_OE_IN(ser[1:0]), .ASYNC_RX_OUT(a_rx),
		.CLOCKED_RX_OUT(c_rx), .SERIAL_CLK_PIN_OUT(ck_pin)
	);

	board_pins_model i_board (
		.oe_in(p_oe), .drv_in(p_out), .lvl_in(lvl), .pin_out(p_in)
	);

	// Free-running clock and a hang limit far above the run length
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	task automatic chk(input byte_t seen, input byte_t exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One strobe cycle; read data are taken just after the next edge
	task automatic bus(input addr_t a, input logic w, input byte_t d,
		input logic b, input logic [2:0] n);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		bop <= b;
		bnum <= n;
		wr <= w;
		rd <= !w;
		@(posedge core_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask

	task automatic wr8(input addr_t a, input byte_t d);
		bus(a, 1'b1, d, 1'b0, 3'h0);
	endtask

	task automatic rd8(input addr_t a);
		bus(a, 1'b0, 8'h00, 1'b0, 3'h0);
	endtask

	task automatic settle();
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	// Register read value after writing w: fixed bits keep their level
	function automatic byte_t rexp(input int i, input byte_t w);
		return (w & reg_mask[i]) | (reg_fix[i] & ~reg_mask[i]);
	endfunction

	task automatic test_done();
		$display("Compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		int i, k, c;
		logic [2:0] n;
		byte_t d, v, m;
		logic t, co;
		void'($urandom(9385));
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		// Reset values, then an unmapped place
		for (i = 0; i < 11; i++) begin
			rd8(reg_addr[i]);
			chk(rdata, reg_fix[i]);
		end
		wr8(32'hfffff100, 8'hff);
		rd8(32'hfffff100);
		chk(rdata, 8'h00);
		// Random byte and bit accesses over every direction, enable and select register
		for (k = 0; k < 3; k++) begin
			for (i = 0; i < 11; i++) begin
				d = 8'($urandom);
				if (i == 4 || i == 5) d &= 8'hf5;
				if (i == 2) d |= 8'h03;
				wr8(reg_addr[i], d);
				rd8(reg_addr[i]);
				m = rexp(i, d);
				chk(rdata, m);
				n = 3'($urandom);
				v = 8'($urandom);
				if (!reg_mask[i][n]) v[0] = reg_fix[i][n];
				bus(reg_addr[i], 1'b1, v, 1'b1, n);
				m[n] = v[0];
				m = rexp(i, m);
				rd8(reg_addr[i]);
				chk(rdata, m);
				bus(reg_addr[i], 1'b0, 8'h00, 1'b1, n);
				chk(rdata, {7'h00, m[n]});
			end
		end
		// Writes that try to change fixed bits are dropped
		wr8(`ADDR_PORT2_DIRECTION, 8'h00);
		rd8(`ADDR_PORT2_DIRECTION);
		chk(rdata, 8'h03);
		wr8(`ADDR_PORT2_FUNC_EN, 8'h02);
		rd8(`ADDR_PORT2_FUNC_EN);
		chk(rdata, 8'h01);
		for (i = 0; i < 11; i++) wr8(reg_addr[i], reg_fix[i]);
		// Plain port mode: direction, latch and data read per port
		for (k = 0; k < 24; k++) begin
			i = k % 4;
			@(posedge core_clk);
			lvl <= $urandom;
			d = 8'($urandom);
			if (i == 2) d |= 8'h03;
			v = 8'($urandom);
			wr8(reg_addr[i], d);
			wr8(data_addr[i], v);
			settle();
			m = ~rexp(i, d);
			chk(p_oe[i], m);
			chk(p_out[i] & m, v & m);
			rd8(data_addr[i]);
			chk(rdata, ((lvl[i] & ~m) | (v & m)) & pin_set[i]);
		end
		for (i = 0; i < 4; i++) wr8(reg_addr[i], reg_fix[i]);
		// Latches low before control mode, so no stray pulse
		wr8(data_addr[0], 8'h00);
		wr8(data_addr[1], 8'h00);
		wr8(`ADDR_PORT0_FUNC_EN, 8'hf5);
		wr8(`ADDR_PORT1_FUNC_EN, 8'hf5);
		wr8(`ADDR_PORT3_FUNC_EN, 8'h18);
		for (k = 0; k < 8; k++) begin
			@(posedge core_clk);
			lvl <= $urandom;
			per <= 6'($urandom);
			d = (k == 0) ? 8'hf0 : byte_t'($urandom);
			wr8(`ADDR_PORT0_FUNC_SEL, d);
			wr8(`ADDR_PORT1_FUNC_SEL, d);
			settle();
			chk({clr_a, p_out[0][0], clr_b, p_out[1][0], cnt_c, irq_c, 2'b00},
				{lvl[0][2], per[5], lvl[1][2], per[4], lvl[3][3], lvl[3][4],
				2'b00});
			chk(p_oe[0], 8'h01);
			chk({irq_a, dreq}, {lvl[0][7:4] & ~d[7:4],
				lvl[0][7:4] & d[7:4]});
			chk(p_oe[1], {d[7:4], 4'h1});
			chk({irq_b, p_out[1][7:4] & d[7:4]}, {lvl[1][7:4] & ~d[7:4],
				per[3:0] & d[7:4]});
		end
		// Back to port mode with selects all set: selects must not matter
		wr8(`ADDR_PORT0_FUNC_SEL, 8'hf0);
		wr8(`ADDR_PORT1_FUNC_SEL, 8'hf0);
		wr8(`ADDR_PORT0_FUNC_EN, 8'h00);
		wr8(`ADDR_PORT1_FUNC_EN, 8'h00);
		wr8(`ADDR_PORT3_FUNC_EN, 8'h00);
		settle();
		chk({irq_a, dreq}, 8'h00);
		chk({irq_b, clr_a, clr_b, cnt_c, irq_c}, 8'h00);
		chk(p_oe[1] | p_oe[0], 8'h00);
		// Serial roles in both variants; direction bits stay at 1
		wr8(`ADDR_PORT2_FUNC_EN, 8'hfc);
		for (k = 0; k < 8; k++) begin
			@(posedge core_clk);
			lvl <= $urandom;
			ser <= 10'($urandom);
			s_mode <= k[1:0];
			settle();
			chk({7'h00, nmi}, {7'h00, lvl[2][0]});
			for (c = 0; c < 2; c++) begin
				t = s_mode[c] ? ser[6 + c] : ser[8 + c];
				co = s_mode[c] & ser[c];
				chk({p_oe[2][2 + 3 * c], p_oe[2][4 + 3 * c],
					p_out[2][2 + 3 * c] & ser[4 + c], p_out[2][4 + 3 * c] & co,
					a_rx[c], c_rx[c], ck_pin[c], 1'b0},
					{ser[4 + c], co, t & ser[4 + c], ser[2 + c] & co,
					!s_mode[c] & lvl[2][3 + 3 * c],
					s_mode[c] & lvl[2][3 + 3 * c],
					co ? ser[2 + c] : lvl[2][4 + 3 * c], 1'b0});
			end
		end
		test_done();
	end
endmodule

bind port_pin_mux port_pin_mux_assertions i_chk (
	.CORE_CLK_IN, .NRST_IN, .ADDR_IN, .RD_IN, .BIT_OP_IN, .RDATA_OUT,
	.P2_IN, .P2_OE_OUT, .EXT_IRQ_GROUP_A_OUT, .DMA_REQUEST_LINE_OUT,
	.ASYNC_RX_OUT, .CLOCKED_RX_OUT, .NMI_OUT
);
